// [rtl/fdcrs_pkg.sv]
// fdcrs_pkg: constants for the first result status byte logic.
// assumes a single 10 MHz clock and a controller-level command sequencer.
package fdcrs_pkg;
	localparam int          CLK_HZ          = 10_000_000;
	localparam logic [6:0]  MAX_STEPS       = 7'h4d;
	localparam logic [6:0]  STEP_RST        = 7'h00;
	localparam logic [7:0]  ST_RST          = 8'h00;
	localparam int          POS_TCODE_HI    = 7;
	localparam int          POS_TCODE_LO    = 6;
	localparam int          POS_SEEK_END    = 5;
	localparam int          POS_EQUIP_FAULT = 4;
	localparam int          POS_NOT_READY   = 3;
	localparam logic [1:0]  TC_NORMAL       = 2'h0;
	localparam logic [1:0]  TC_ABNORMAL     = 2'h1;
	localparam logic [1:0]  TC_INVALID      = 2'h2;
	localparam logic [1:0]  TC_READY_CHG    = 2'h3;
	localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;

	typedef enum logic [2:0] {
		CMD_OTHER,
		CMD_READ,
		CMD_WRITE,
		CMD_SEEK,
		CMD_RECAL,
		CMD_INVALID
	} fdcrs_cmd_t;
endpackage : fdcrs_pkg

// [rtl/fdcrs_if.sv]
// fdcrs_if: step counter link between the status core and its counter.
// assumes both ends share mclk.
`timescale 1ns/1ns
interface fdcrs_if;
	logic       clear;
	logic       step;
	logic       limit;
	modport core (output clear, output step, input limit);
	modport cnt  (input clear, input step, output limit);
endinterface : fdcrs_if

// [rtl/fdcrs_step_cnt.sv]
// fdcrs_step_cnt: counts step pulses of a recalibrate.
// assumes step is a one-cycle pulse per issued step.
`timescale 1ns/1ns
module fdcrs_step_cnt
	import fdcrs_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// link to core
	fdcrs_if.cnt      lnk
);
	logic [6:0] count;
	logic [6:0] next_count;

	always_comb begin
		next_count = count;
		if (lnk.clear) begin
			next_count = STEP_RST;
		end else if (lnk.step && count != MAX_STEPS) begin
			next_count = count + 7'h01;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			count <= STEP_RST;
		end else begin
			count <= next_count;
		end
	end

	assign lnk.limit = (count == MAX_STEPS);

	a_step_saturate: assert property (@(posedge mclk) disable iff (!nrst)
		(count == MAX_STEPS && !lnk.clear) |=> count == MAX_STEPS)
		else $error("step count left its limit");
	a_step_inc: assert property (@(posedge mclk) disable iff (!nrst)
		(lnk.step && !lnk.clear && count < MAX_STEPS) |=> count == $past(count) + 7'h01)
		else $error("step count missed a pulse");
endmodule : fdcrs_step_cnt

// [rtl/fdcrs_status0.sv]
// fdcrs_status0: termination code and seek/fault/not-ready flags of status byte 0.
// assumes the sequencer pulses cmd_start with the decoded command and cmd_done at end;
// drive inputs are synchronous to mclk. register port: read data one cycle later.
`timescale 1ns/1ns

// Overview of operation
// - top two bits carry termination code
// - ready change in command aborts with ready change termination code
// - seek completion sets seek end flag
// - drive fault sets equipment fault flag
// - 77 recalibrate steps without track zero
// - read/write to not-ready drive flags
// - side one on single sided drive flags
module fdcrs_status0
	import fdcrs_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// command sequencer
	input  wire logic              cmd_start,
	input  wire fdcrs_pkg::fdcrs_cmd_t cmd_kind,
	input  wire logic              cmd_head,
	input  wire logic              cmd_done,
	input  wire logic              step_pulse_in,
	// selected drive
	input  wire logic              drv_ready,
	input  wire logic              drv_fault,
	input  wire logic              drv_track0,
	input  wire logic              drv_two_sided,
	// register port
	input  wire logic [1:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [7:0]             reg_rdata,
	// results
	output logic                   cmd_abort,
	output logic                   step_stop,
	output logic                   irq
);
	import fdcrs_pkg::*;

	localparam logic [1:0] ADDR_STATUS0  = 2'h0;
	localparam logic [1:0] ADDR_IRQ_STAT = 2'h1;
	localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
	localparam int         IRQ_ABORT     = 0;
	localparam int         IRQ_FAULT     = 1;
	localparam int         IRQ_DONE      = 2;

	typedef enum logic [1:0] {S_IDLE, S_RUN, S_RECAL} fdcrs_state_t;

	fdcrs_if lnk ();

	fdcrs_state_t state, next_state;
	logic [1:0] termination_code, next_termination_code;
	logic       seek_end_flag, next_seek_end_flag;
	logic       equipment_fault_flag, next_equipment_fault_flag;
	logic       drive_not_ready_flag, next_drive_not_ready_flag;
	logic       ready_prev, next_ready_prev;
	logic       is_seek, next_is_seek;
	logic       next_cmd_abort, next_step_stop;
	logic [7:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [7:0] next_reg_rdata, ev;
	logic       next_irq;
	logic [7:0] status0;

	assign status0 = {termination_code, seek_end_flag, equipment_fault_flag,
	                  drive_not_ready_flag, 3'h0};

	fdcrs_step_cnt u_cnt (
		.mclk (mclk),
		.nrst (nrst),
		.lnk  (lnk)
	);

	assign lnk.clear = cmd_start;
	assign lnk.step  = step_pulse_in && state == S_RECAL;

	always_comb begin
		next_state                = state;
		next_termination_code     = termination_code;
		next_seek_end_flag        = seek_end_flag;
		next_equipment_fault_flag = equipment_fault_flag;
		next_drive_not_ready_flag = drive_not_ready_flag;
		next_ready_prev           = drv_ready;
		next_is_seek              = is_seek;
		next_cmd_abort            = 1'b0;
		next_step_stop            = 1'b0;
		ev                        = 8'h00;
		if (cmd_start) begin
			next_termination_code     = TC_NORMAL;
			next_seek_end_flag        = 1'b0;
			next_equipment_fault_flag = 1'b0;
			next_drive_not_ready_flag = 1'b0;
			next_is_seek              = (cmd_kind == CMD_SEEK);
			next_state                = S_RUN;
			case (cmd_kind)
				CMD_INVALID: begin
					next_termination_code = TC_INVALID;
					next_state            = S_IDLE;
					ev[IRQ_DONE]          = 1'b1;
				end
				CMD_READ, CMD_WRITE: begin
					if (!drv_ready || (cmd_head && !drv_two_sided)) begin
						next_drive_not_ready_flag = 1'b1;
						next_termination_code     = TC_ABNORMAL;
						next_cmd_abort            = 1'b1;
						next_state                = S_IDLE;
						ev[IRQ_ABORT]             = 1'b1;
					end
				end
				CMD_RECAL: begin
					next_state = S_RECAL;
				end
				default: begin
				end
			endcase
		end else if (state != S_IDLE) begin
			if (drv_ready != ready_prev) begin
				next_termination_code = TC_READY_CHG;
				next_cmd_abort        = 1'b1;
				next_state            = S_IDLE;
				ev[IRQ_ABORT]         = 1'b1;
			end else if (drv_fault) begin
				next_equipment_fault_flag = 1'b1;
				next_termination_code     = TC_ABNORMAL;
				next_cmd_abort            = 1'b1;
				next_state                = S_IDLE;
				ev[IRQ_FAULT]             = 1'b1;
			end else if (state == S_RECAL && drv_track0) begin
				next_state = S_RUN;
			end else if (state == S_RECAL && lnk.limit) begin
				next_equipment_fault_flag = 1'b1;
				next_termination_code     = TC_ABNORMAL;
				next_step_stop            = 1'b1;
				next_state                = S_IDLE;
				ev[IRQ_FAULT]             = 1'b1;
			end else if (cmd_done) begin
				next_seek_end_flag = 1'b1;
				next_state         = S_IDLE;
				ev[IRQ_DONE]       = 1'b1;
			end
		end
	end

	// interrupt status: set wins over write-one-to-clear
	always_comb begin
		next_irq_stat  = irq_stat;
		next_irq_mask  = irq_mask;
		next_reg_rdata = 8'h00;
		if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~reg_wdata;
		end
		if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
			next_irq_mask = reg_wdata;
		end
		next_irq_stat = next_irq_stat | ev;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_STATUS0:  next_reg_rdata = status0;
				ADDR_IRQ_STAT: next_reg_rdata = irq_stat;
				ADDR_IRQ_MASK: next_reg_rdata = irq_mask;
				default:       next_reg_rdata = 8'h00;
			endcase
		end
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state                <= S_IDLE;
			termination_code     <= TC_NORMAL;
			seek_end_flag        <= 1'b0;
			equipment_fault_flag <= 1'b0;
			drive_not_ready_flag <= 1'b0;
			ready_prev           <= 1'b0;
			is_seek              <= 1'b0;
			cmd_abort            <= 1'b0;
			step_stop            <= 1'b0;
			irq_stat             <= ST_RST;
			irq_mask             <= IRQ_MASK_RST;
			reg_rdata            <= ST_RST;
			irq                  <= 1'b0;
		end else begin
			state                <= next_state;
			termination_code     <= next_termination_code;
			seek_end_flag        <= next_seek_end_flag && next_is_seek;
			equipment_fault_flag <= next_equipment_fault_flag;
			drive_not_ready_flag <= next_drive_not_ready_flag;
			ready_prev           <= next_ready_prev;
			is_seek              <= next_is_seek;
			cmd_abort            <= next_cmd_abort;
			step_stop            <= next_step_stop;
			irq_stat             <= next_irq_stat;
			irq_mask             <= next_irq_mask;
			reg_rdata            <= next_reg_rdata;
			irq                  <= next_irq;
		end
	end

	a_code_legal: assert property (@(posedge mclk) disable iff (!nrst)
		termination_code == TC_INVALID |-> status0[5:3] == 3'h0)
		else $error("invalid command carries flags");
	a_ready_abort: assert property (@(posedge mclk) disable iff (!nrst)
		(state != S_IDLE && !cmd_start && drv_ready != ready_prev)
		|=> termination_code == TC_READY_CHG && cmd_abort)
		else $error("ready change not aborted");
	a_seek_end: assert property (@(posedge mclk) disable iff (!nrst)
		(state == S_RUN && is_seek && !cmd_start && cmd_done && drv_ready == ready_prev
		 && !drv_fault) |=> seek_end_flag)
		else $error("seek end not set");
	a_fault_flag: assert property (@(posedge mclk) disable iff (!nrst)
		(state != S_IDLE && !cmd_start && drv_fault && drv_ready == ready_prev)
		|=> equipment_fault_flag)
		else $error("fault not flagged");
	a_recal_limit: assert property (@(posedge mclk) disable iff (!nrst)
		(state == S_RECAL && !cmd_start && lnk.limit && !drv_track0 && !drv_fault
		 && drv_ready == ready_prev) |=> equipment_fault_flag && step_stop)
		else $error("recalibrate limit missed");
	a_not_ready: assert property (@(posedge mclk) disable iff (!nrst)
		(cmd_start && (cmd_kind == CMD_READ || cmd_kind == CMD_WRITE) && !drv_ready)
		|=> drive_not_ready_flag)
		else $error("not ready not flagged");
	a_single_side: assert property (@(posedge mclk) disable iff (!nrst)
		(cmd_start && (cmd_kind == CMD_READ || cmd_kind == CMD_WRITE) && cmd_head
		 && !drv_two_sided) |=> drive_not_ready_flag)
		else $error("side one not flagged");
	a_start_clear: assert property (@(posedge mclk) disable iff (!nrst)
		(cmd_start && cmd_kind == CMD_SEEK) |=> status0 == 8'h00)
		else $error("flags not cleared");
	a_irq_level: assert property (@(posedge mclk) disable iff (!nrst)
		irq == |($past(next_irq_stat) & $past(next_irq_mask)) || $rose(nrst))
		else $error("irq level wrong");

	c_seek_done: cover property (@(posedge mclk) disable iff (!nrst) $rose(seek_end_flag));
	c_recal_fail: cover property (@(posedge mclk) disable iff (!nrst) step_stop);
	c_ready_abort: cover property (@(posedge mclk) disable iff (!nrst)
		cmd_abort && !drive_not_ready_flag && !equipment_fault_flag);
	c_invalid: cover property (@(posedge mclk) disable iff (!nrst)
		termination_code == TC_INVALID);
endmodule : fdcrs_status0

// [testbench/fdcrs_drive_model.sv]
// fdcrs_drive_model: behavioural selected drive seen by the status logic.
// assumes the bench sets its levels and hands it the step pulses it issues.
`timescale 1ns/1ns
module fdcrs_drive_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// bench control
	input  wire logic       step,
	input  wire logic       set_ready,
	input  wire logic       set_fault,
	input  wire logic       set_two,
	input  wire logic [6:0] t0_after,
	// drive levels
	output logic            drv_ready,
	output logic            drv_fault,
	output logic            drv_track0,
	output logic            drv_two_sided
);
	logic [6:0] pos;
	// zero in t0_after means a head that never reaches track zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			pos <= 7'h00;
		else if (step && pos != 7'h7f)
			pos <= pos + 7'h01;
	end
	assign drv_track0    = (t0_after != 7'h00) && (pos >= t0_after);
	assign drv_ready     = set_ready;
	assign drv_fault     = set_fault;
	assign drv_two_sided = set_two;
endmodule : fdcrs_drive_model

// [testbench/tb_fdcrs_status0.sv]
// tb_fdcrs_status0: scenario bench for the status byte 0 logic.
// assumes the drive model stands for the selected drive.
`timescale 1ns/1ns
module tb_fdcrs_status0;
	import fdcrs_pkg::*;
	logic mclk, nrst, cmd_start, cmd_head, cmd_done, step, rdy, flt, two, reg_wr, reg_rd;
	fdcrs_cmd_t cmd_kind;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v, aborts, stops, mismatches, n_checks;
	logic cmd_abort, step_stop, irq, d_rdy, d_flt, d_t0, d_two;
	logic [6:0] t0;
	int cyc;
	fdcrs_drive_model i_fdcrs_drive_model (.mclk(mclk), .nrst(nrst), .step(step),
		.set_ready(rdy), .set_fault(flt), .set_two(two), .t0_after(t0),
		.drv_ready(d_rdy), .drv_fault(d_flt), .drv_track0(d_t0), .drv_two_sided(d_two));
	fdcrs_status0 i_fdcrs_status0 (.mclk(mclk), .nrst(nrst), .cmd_start(cmd_start),
		.cmd_kind(cmd_kind), .cmd_head(cmd_head), .cmd_done(cmd_done), .step_pulse_in(step),
		.drv_ready(d_rdy), .drv_fault(d_flt), .drv_track0(d_t0), .drv_two_sided(d_two),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cmd_abort(cmd_abort), .step_stop(step_stop), .irq(irq));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cmd_abort === 1'b1) aborts <= aborts + 8'h01;
		if (step_stop === 1'b1) stops <= stops + 8'h01;
		if (cyc == 20000) begin
			mismatches = mismatches + 8'h01;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks = n_checks + 8'h01;
		if (seen !== exp) begin
			mismatches = mismatches + 8'h01;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic pulse_cmd(input fdcrs_cmd_t k, input logic h);
		@(posedge mclk);
		cmd_start <= 1'b1; cmd_kind <= k; cmd_head <= h;
		@(posedge mclk);
		cmd_start <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : pulse_cmd
	task automatic pulse_done();
		@(posedge mclk);
		cmd_done <= 1'b1;
		@(posedge mclk);
		cmd_done <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : pulse_done
	task automatic drive(input logic r, input logic f, input logic t);
		@(posedge mclk);
		rdy <= r; flt <= f; two <= t;
	endtask : drive
	task automatic t_seek_irq();
		rd(2'h2); chk(v, IRQ_MASK_RST);
		pulse_cmd(CMD_SEEK, 1'b0); pulse_done();
		rd(2'h0); chk(v, 8'h20);
		chk({7'h00, irq}, 8'h00);
		wr(2'h2, 8'h04); repeat (3) @(posedge mclk);
		chk({7'h00, irq}, 8'h01);
		wr(2'h1, 8'h07); repeat (3) @(posedge mclk);
		chk({7'h00, irq}, 8'h00);
		rd(2'h3); chk(v, 8'h00);
	endtask : t_seek_irq
	task automatic t_not_ready(input fdcrs_cmd_t k, input logic r, input logic h);
		logic [7:0] a0;
		a0 = aborts;
		drive(r, 1'b0, 1'b0);
		pulse_cmd(k, h);
		rd(2'h0); chk(v, 8'h48);
		chk(aborts - a0, 8'h01);
	endtask : t_not_ready
	task automatic t_in_cmd(input logic r, input logic f, input logic [7:0] exp);
		drive(1'b1, 1'b0, 1'b1);
		pulse_cmd(CMD_READ, 1'b1);
		rd(2'h0); chk(v, 8'h00);
		drive(r, f, 1'b1); repeat (3) @(posedge mclk);
		rd(2'h0); chk(v, exp);
		drive(1'b1, 1'b0, 1'b1);
	endtask : t_in_cmd
	task automatic t_recal();
		logic [7:0] s0;
		s0 = stops;
		pulse_cmd(CMD_RECAL, 1'b0);
		repeat (76) begin
			@(posedge mclk) step <= 1'b1;
			@(posedge mclk) step <= 1'b0;
		end
		repeat (3) @(posedge mclk);
		chk(stops - s0, 8'h00);
		@(posedge mclk) step <= 1'b1;
		@(posedge mclk) step <= 1'b0;
		repeat (3) @(posedge mclk);
		// stop and fault at the limit
		chk(stops - s0, 8'h01);
		rd(2'h0); chk(v, 8'h50);
	endtask : t_recal
	task automatic t_recal_ok();
		logic [7:0] s0;
		s0 = stops;
		t0 <= 7'h03;
		pulse_cmd(CMD_RECAL, 1'b0);
		repeat (80) begin
			@(posedge mclk) step <= 1'b1;
			@(posedge mclk) step <= 1'b0;
		end
		repeat (3) @(posedge mclk);
		chk(stops - s0, 8'h00);
		pulse_done();
		rd(2'h0); chk(v, 8'h00);
		t0 <= 7'h00;
	endtask : t_recal_ok
	task automatic t_clear_invalid();
		pulse_cmd(CMD_OTHER, 1'b0);
		rd(2'h0); chk(v, ST_RST);
		pulse_done();
		pulse_cmd(CMD_INVALID, 1'b0);
		rd(2'h0); chk(v, 8'h80);
	endtask : t_clear_invalid
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 8'h00 && n_checks != 8'h00)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		{nrst, cmd_start, cmd_head, cmd_done, step, reg_wr, reg_rd, flt} = 8'h00;
		{rdy, two, reg_addr, reg_wdata} = 12'hc00;
		cmd_kind = CMD_OTHER;
		{aborts, stops, mismatches, n_checks} = 32'h0;
		cyc = 0;
		t0 = 7'h00;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		rd(2'h0); chk(v, ST_RST);
		t_seek_irq();
		t_not_ready(CMD_READ, 1'b0, 1'b0);
		t_not_ready(CMD_WRITE, 1'b1, 1'b1);
		t_in_cmd(1'b0, 1'b0, 8'hc0);
		t_in_cmd(1'b1, 1'b1, 8'h50);
		t_recal();
		t_recal_ok();
		t_clear_invalid();
		tally_and_finish();
	end
endmodule : tb_fdcrs_status0
